// File: rtl/tlp_map.vh
`ifndef TLP_MAP_VH
`define TLP_MAP_VH
`define TLP_MODE_W 3
`define TLP_MODE_1 3'h1
`define TLP_MODE_2 3'h2
`define TLP_MODE_3 3'h3
`define TLP_MODE_4 3'h4
`define TLP_MODE_5 3'h5
`define TLP_MODE_6 3'h6
`define TLP_VAR_QUAD 2'h2
`define TLP_VAR_DUAL 2'h1
`define TLP_VAR_SINGLE 2'h0
`define TLP_LANE_W 40
`define TLP_SMP_W 9
`define TLP_CODE_8B10B 1'h0
`define TLP_CODE_64B66B 1'h1
`endif

// File: rtl/tlp_lane_en.v
`timescale 1ns/1ps
`include "tlp_map.vh"
module tlp_lane_en (
  input wire [2:0] link_mode_select,
  input wire [1:0] variant,
  output reg [5:0] lane_en
);
  // number of lanes by mode and variant; always the lowest indices
  always @* begin
    case (link_mode_select)
      // the unused variant code falls through to the dual lane count
      `TLP_MODE_1, `TLP_MODE_6: begin
        if (variant == `TLP_VAR_QUAD) begin
          lane_en = 6'h3F;
        end else if (variant == `TLP_VAR_SINGLE) begin
          lane_en = 6'h03;
        end else begin
          lane_en = 6'h07;
        end
      end
      `TLP_MODE_2, `TLP_MODE_3: begin
        if (variant == `TLP_VAR_QUAD) begin
          lane_en = 6'h0F;
        end else if (variant == `TLP_VAR_SINGLE) begin
          lane_en = 6'h01;
        end else begin
          lane_en = 6'h03;
        end
      end
      `TLP_MODE_4: begin
        if (variant == `TLP_VAR_QUAD) begin
          lane_en = 6'h07;
        end else if (variant == `TLP_VAR_SINGLE) begin
          lane_en = 6'h01;
        end else begin
          lane_en = 6'h03;
        end
      end
      `TLP_MODE_5: begin
        lane_en = (variant == `TLP_VAR_QUAD) ? 6'h03 : 6'h01;
      end
      default: begin
        lane_en = 6'h00;
      end
    endcase
  end
endmodule

// File: rtl/tlp_packer.v
`timescale 1ns/1ps
`include "tlp_map.vh"
module tlp_packer (
  input wire sys_clk,
  input wire nrst,
  input wire [2:0] link_mode_select,
  input wire [1:0] variant,
  input wire frame_valid,
  input wire [35:0] smp_a,
  input wire [35:0] smp_b,
  input wire [35:0] smp_c,
  input wire [35:0] smp_d,
  output reg [39:0] serial_lane_0,
  output reg [39:0] serial_lane_1,
  output reg [39:0] serial_lane_2,
  output reg [39:0] serial_lane_3,
  output reg [39:0] serial_lane_4,
  output reg [39:0] serial_lane_5,
  output reg [5:0] lane_power_en,
  output reg line_code_64b66b,
  output reg frame_out_valid
);
  // samples: [35:27]=s0 [26:18]=s1 [17:9]=s2 [8:0]=s3, each msb first
  // lanes are left aligned: octet 0 sits in [39:32]; unused octets zero
  wire [5:0] lane_en;
  reg [39:0] l0_nxt;
  reg [39:0] l1_nxt;
  reg [39:0] l2_nxt;
  reg [39:0] l3_nxt;
  reg [39:0] l4_nxt;
  reg [39:0] l5_nxt;
  reg [35:0] bq;
  reg [35:0] cq;
  reg [35:0] dq;
  reg [8:0] a0;
  reg [8:0] a1;
  reg [8:0] b0;
  reg [8:0] b1;
  reg [8:0] c0;
  reg [8:0] c1;
  reg [8:0] d0;
  reg [8:0] d1;

  function [8:0] smp;
    input [35:0] v;
    input [1:0] i;
    begin
      smp = v[35 - 9 * i -: 9];
    end
  endfunction

  // 12-bit word, three zero tail bits
  function [11:0] pad12;
    input [8:0] s;
    begin
      pad12 = {s, 3'h0};
    end
  endfunction

  // 8-bit modes keep the top eight bits; the lsb is simply dropped
  function [7:0] top8;
    input [8:0] s;
    begin
      top8 = s[8:1];
    end
  endfunction

  // four 10-bit words, one zero tail each, oldest sample first
  function [39:0] pack10;
    input [35:0] v;
    begin
      pack10 = {v[35:27], 1'h0, v[26:18], 1'h0, v[17:9], 1'h0, v[8:0], 1'h0};
    end
  endfunction

  tlp_lane_en u_lane_en (
    .link_mode_select(link_mode_select),
    .variant(variant),
    .lane_en(lane_en)
  );

  // absent channels are forced to zero so a single part emits 0x00 fill
  always @* begin
    bq = (variant == `TLP_VAR_SINGLE) ? 36'h0 : smp_b;
    cq = (variant == `TLP_VAR_QUAD) ? smp_c : 36'h0;
    dq = (variant == `TLP_VAR_QUAD) ? smp_d : 36'h0;
    a0 = smp(smp_a, 2'h0);
    a1 = smp(smp_a, 2'h1);
    b0 = smp(bq, 2'h0);
    b1 = smp(bq, 2'h1);
    c0 = smp(cq, 2'h0);
    c1 = smp(cq, 2'h1);
    d0 = smp(dq, 2'h0);
    d1 = smp(dq, 2'h1);
  end

  // one case per lane; every field is cut to its exact width so no
  // concatenation can spill past 40 bits and push the first octet out
  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l0_nxt = {pad12(a0), a1[8:5], 24'h0};
      end
      `TLP_MODE_2: begin
        l0_nxt = {top8(a0), 32'h0};
      end
      `TLP_MODE_3: begin
        l0_nxt = pack10(smp_a);
      end
      `TLP_MODE_4: begin
        l0_nxt = {pad12(a0), b0[8:5], 24'h0};
      end
      `TLP_MODE_5: begin
        l0_nxt = {top8(a0), top8(b0), 24'h0};
      end
      default: begin
        l0_nxt = 40'h0;
      end
    endcase
  end

  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l1_nxt = {a1[4:0], 3'h0, top8(b0), 24'h0};
      end
      `TLP_MODE_2: begin
        l1_nxt = {top8(b0), 32'h0};
      end
      `TLP_MODE_3: begin
        l1_nxt = pack10(bq);
      end
      `TLP_MODE_4: begin
        l1_nxt = {b0[4:0], 3'h0, top8(c0), 24'h0};
      end
      `TLP_MODE_5: begin
        l1_nxt = {top8(c0), top8(d0), 24'h0};
      end
      default: begin
        l1_nxt = 40'h0;
      end
    endcase
  end

  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l2_nxt = {b0[0], 3'h0, pad12(b1), 24'h0};
      end
      `TLP_MODE_2: begin
        l2_nxt = {top8(c0), 32'h0};
      end
      `TLP_MODE_3: begin
        l2_nxt = pack10(cq);
      end
      `TLP_MODE_4: begin
        l2_nxt = {c0[0], 3'h0, pad12(d0), 24'h0};
      end
      default: begin
        l2_nxt = 40'h0;
      end
    endcase
  end

  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l3_nxt = {pad12(c0), c1[8:5], 24'h0};
      end
      `TLP_MODE_2: begin
        l3_nxt = {top8(d0), 32'h0};
      end
      `TLP_MODE_3: begin
        l3_nxt = pack10(dq);
      end
      default: begin
        l3_nxt = 40'h0;
      end
    endcase
  end

  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l4_nxt = {c1[4:0], 3'h0, top8(d0), 24'h0};
      end
      default: begin
        l4_nxt = 40'h0;
      end
    endcase
  end

  always @* begin
    case (link_mode_select)
      `TLP_MODE_1, `TLP_MODE_6: begin
        l5_nxt = {d0[0], 3'h0, pad12(d1), 24'h0};
      end
      default: begin
        l5_nxt = 40'h0;
      end
    endcase
  end

  // lanes powered down on a valid frame load zero; without frame_valid every lane keeps its last value
  always @(posedge sys_clk) begin
    if (!nrst) begin
      serial_lane_0 <= 40'h0;
      serial_lane_1 <= 40'h0;
      serial_lane_2 <= 40'h0;
      serial_lane_3 <= 40'h0;
      serial_lane_4 <= 40'h0;
      serial_lane_5 <= 40'h0;
      lane_power_en <= 6'h00;
      line_code_64b66b <= `TLP_CODE_8B10B;
      frame_out_valid <= 1'h0;
    end else begin
      lane_power_en <= lane_en;
      line_code_64b66b <= (link_mode_select == `TLP_MODE_4) ||
                          (link_mode_select == `TLP_MODE_5) ||
                          (link_mode_select == `TLP_MODE_6);
      frame_out_valid <= frame_valid;
      if (frame_valid) begin
        serial_lane_0 <= lane_en[0] ? l0_nxt : 40'h0;
        serial_lane_1 <= lane_en[1] ? l1_nxt : 40'h0;
        serial_lane_2 <= lane_en[2] ? l2_nxt : 40'h0;
        serial_lane_3 <= lane_en[3] ? l3_nxt : 40'h0;
        serial_lane_4 <= lane_en[4] ? l4_nxt : 40'h0;
        serial_lane_5 <= lane_en[5] ? l5_nxt : 40'h0;
      end
    end
  end
endmodule

// File: sim/tlp_packer_monitor.sv
`timescale 1ns/1ps
module tlp_mon (
  input wire sys_clk,
  input wire nrst,
  input wire [2:0] link_mode_select,
  input wire [1:0] variant,
  input wire frame_valid,
  input wire [35:0] smp_a,
  input wire [39:0] serial_lane_0,
  input wire [39:0] serial_lane_1,
  input wire [5:0] lane_power_en,
  input wire line_code_64b66b,
  input wire frame_out_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire f1 = frame_valid && link_mode_select == 3'h1;
  wire [2:0] m = link_mode_select;
  a_lat_one: assert property (frame_valid |=> frame_out_valid)
    else $error("late frame");
  a_pad_twelve: assert property (f1 |=> serial_lane_0[39:24] ==
    {$past(smp_a[35:27]), 3'h0, $past(smp_a[26:23])}) else $error("mode 1 lane 0");
  a_fill_single: assert property (f1 && variant == 2'h0 |=> serial_lane_1[31:24] == 8'h00)
    else $error("single fill");
  a_quad_six: assert property (f1 && variant == 2'h2 |=> lane_power_en == 6'h3F)
    else $error("quad lanes");
  a_octet_top: assert property (frame_valid && m == 3'h2 |=>
    serial_lane_0[39:32] == $past(smp_a[35:28])) else $error("mode 2 octet");
  a_ten_bit: assert property (frame_valid && m == 3'h3 |=> serial_lane_0 ==
    {$past(smp_a[35:27]), 1'h0, $past(smp_a[26:18]), 1'h0, $past(smp_a[17:9]), 1'h0,
    $past(smp_a[8:0]), 1'h0}) else $error("mode 3 lane 0");
  a_code_sel: assert property (frame_valid |=> line_code_64b66b ==
    ($past(m) > 3'h3 && $past(m) < 3'h7)) else $error("line code");
  a_low_lanes: assert property (((lane_power_en + 6'h01) & lane_power_en) == 6'h00)
    else $error("lanes not lowest");
  cover property (f1 && variant == 2'h2);
  cover property (frame_valid && m == 3'h3);
  cover property (frame_valid && frame_out_valid);
endmodule
bind tlp_packer tlp_mon u_mon (.sys_clk, .nrst, .link_mode_select, .variant, .frame_valid,
  .smp_a, .serial_lane_0, .serial_lane_1, .lane_power_en, .line_code_64b66b, .frame_out_valid);

// File: sim/tlp_rx_model.sv
`timescale 1ns/1ps
module tlp_rx_model (
  input wire [39:0] serial_lane_0,
  input wire [39:0] serial_lane_1,
  input wire [39:0] serial_lane_2,
  output wire [35:0] rx_ab
);
  // mode 1/6 unpack of A0 A1 B0 B1, padding dropped; other modes judged by slices
  assign rx_ab = {serial_lane_0[39:31], serial_lane_0[27:24], serial_lane_1[39:35],
    serial_lane_1[31:24], serial_lane_2[39], serial_lane_2[35:27]};
endmodule

// File: sim/transport_lane_packer_tb.sv
`timescale 1ns/1ps
module transport_lane_packer_tb;
  reg sys_clk = 1'h0;
  reg nrst = 1'h0;
  reg fv = 1'h0;
  reg [2:0] md = 3'h0;
  reg [1:0] vr = 2'h2;
  reg [35:0] sa = 36'h1A2B3C4D5;
  reg [35:0] sb = 36'h9E8D7C6B5;
  reg [35:0] sc = 36'h5F00FF0A3;
  reg [35:0] sd = 36'hC3C3C3C3C;
  wire [39:0] l0, l1, l2, l3, l4, l5;
  wire [5:0] pen;
  wire code, ov;
  wire [35:0] rx;
  integer errors = 0;
  integer n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  tlp_packer DUT (.sys_clk(sys_clk), .nrst(nrst), .link_mode_select(md), .variant(vr),
    .frame_valid(fv), .smp_a(sa), .smp_b(sb), .smp_c(sc), .smp_d(sd), .serial_lane_0(l0),
    .serial_lane_1(l1), .serial_lane_2(l2), .serial_lane_3(l3), .serial_lane_4(l4),
    .serial_lane_5(l5), .lane_power_en(pen), .line_code_64b66b(code), .frame_out_valid(ov));
  tlp_rx_model u_rx (.serial_lane_0(l0), .serial_lane_1(l1), .serial_lane_2(l2), .rx_ab(rx));
  task chk(input [39:0] got, input [39:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // valid stays high so consecutive calls run back to back
  task send(input [2:0] m, input [1:0] v);
    begin
      @(negedge sys_clk);
      md = m;
      vr = v;
      fv = 1'h1;
      @(negedge sys_clk);
      chk({39'h0, ov}, 40'h1);
    end
  endtask
  task t_mode_one;
    begin
      send(3'h1, 2'h2);
      chk(l0, {sa[35:27], 3'h0, sa[26:23], 24'h0});
      chk({4'h0, rx}, {4'h0, sa[35:18], sb[35:18]});
      chk(l3, {sc[35:27], 3'h0, sc[26:23], 24'h0});
      chk(l4, {sc[22:18], 3'h0, sd[35:28], 24'h0});
      chk(l5, {sd[27], 3'h0, sd[26:18], 3'h0, 24'h0});
      chk({34'h0, pen}, 40'h3F);
      send(3'h1, 2'h0);
      chk({32'h0, l1[31:24]}, 40'h0);
      chk(l2, 40'h0);
      chk({34'h0, pen}, 40'h03);
      send(3'h6, 2'h1);
      chk({4'h0, rx}, {4'h0, sa[35:18], sb[35:18]});
      chk({33'h0, code, pen}, 40'h47);
    end
  endtask
  // reset in mid-run with frames still flowing
  task t_reset_mid;
    begin
      send(3'h6, 2'h2);
      chk(l5, {sd[27], 3'h0, sd[26:18], 3'h0, 24'h0});
      nrst = 1'h0;
      @(negedge sys_clk);
      chk(l0 | l1 | l2 | l3 | l4 | l5, 40'h0);
      chk({33'h0, code, pen}, 40'h0);
      chk({39'h0, ov}, 40'h0);
      nrst = 1'h1;
    end
  endtask
  task t_other_modes;
    begin
      send(3'h2, 2'h2);
      chk({32'h0, l3[39:32]}, {32'h0, sd[35:28]});
      send(3'h3, 2'h2);
      chk(l2, {sc[35:27], 1'h0, sc[26:18], 1'h0, sc[17:9], 1'h0, sc[8:0], 1'h0});
      chk({33'h0, code, pen}, 40'h0F);
      send(3'h4, 2'h2);
      chk(l2, {sc[27], 3'h0, sd[35:27], 3'h0, 24'h0});
      chk({33'h0, code, pen}, 40'h47);
      send(3'h4, 2'h1);
      chk(l1, {sb[31:27], 3'h0, 32'h0});
      chk({33'h0, code, pen}, 40'h43);
      send(3'h4, 2'h0);
      chk(l0, {sa[35:27], 3'h0, 4'h0, 24'h0});
      send(3'h5, 2'h2);
      chk(l1, {sc[35:28], sd[35:28], 24'h0});
      chk({33'h0, code, pen}, 40'h43);
      send(3'h5, 2'h0);
      chk(l0, {sa[35:28], 32'h0});
      send(3'h7, 2'h2);
      chk({34'h0, pen}, 40'h0);
      chk(l0, 40'h0);
      fv = 1'h0;
      @(negedge sys_clk);
      chk({39'h0, ov}, 40'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    nrst = 1'h1;
    t_mode_one;
    t_reset_mid;
    t_other_modes;
    give_verdict;
  end
endmodule
